// >>> verilog/spi_serial_port.sv
// serial peripheral port, master and slave roles, spi framing
`timescale 1ns/1ps
`default_nettype none
module spi_serial_port
   import spi_port_pkg::*;
(
   // system clock and reset
   input wire logic clock,
   input wire logic rst,
   // configuration
   input wire control_type control_one,
   input wire status_cfg_type status_cfg,
   input wire pin_dir_type pin_direction_bit,
   // cpu access to the transfer buffer
   input wire logic buf_write,
   input wire logic [7:0] buf_wdata,
   input wire logic buf_read,
   output logic [7:0] buf_rdata,
   input wire logic write_collision_flag_clear,
   input wire logic irq_clear,
   // status
   output logic buffer_full_flag,
   output logic serial_irq_flag,
   output logic write_collision_flag,
   output logic busy,
   // serial pins
   input wire logic serial_clock_in,
   output logic serial_clock_out,
   output logic serial_clock_oe_n,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_oe_n,
   input wire logic select_pin_n
);

   state_type state_reg, state_next;
   logic [7:0] buffer_reg, buffer_next, tx_hold_reg;
   logic bf_reg, irq_reg, write_collision_flag_reg;
   logic sdi_meta_reg, sdi_sync_reg;
   logic done_meta_reg, done_sync_reg, done_seen_reg;
   logic [5:0] div_reg;
   logic [4:0] tick_reg;
   logic sck_reg, sdo_reg;
   logic [7:0] tx_sh_reg, rx_sh_reg;
   logic [1:0] sample_pipe_reg, end_pipe_reg;
   // link domain
   logic [7:0] link_rx_reg, link_word_reg;
   logic [2:0] link_bit_reg, link_out_reg;
   logic link_tog_reg;

   // role and option decode
   wire en = control_one.enable;
   wire mode_master = control_one.mode == MODE_MASTER_FAST ||
      control_one.mode == MODE_MASTER_MID ||
      control_one.mode == MODE_MASTER_SLOW;
   wire mode_slave = control_one.mode == MODE_SLAVE_SELECT ||
      control_one.mode == MODE_SLAVE_FREE;
   wire is_master = en && mode_master;
   wire is_slave = en && mode_slave;
   wire cpha1 = !status_cfg.edge_active_to_idle;
   wire smp_end = status_cfg.sample_at_end;
   wire ss_used = control_one.mode == MODE_SLAVE_SELECT;
   // rate only matters in master role
   wire [5:0] half_count =
      control_one.mode == MODE_MASTER_FAST ? 6'(RATE_FAST_DIV >> 1) :
      control_one.mode == MODE_MASTER_MID ? 6'(RATE_MID_DIV >> 1) :
      6'(RATE_SLOW_DIV >> 1);

   // master bit timing: ticks every half serial clock period
   wire [4:0] ticks_mid = 5'(BYTE_BITS << 1);
   wire [4:0] last_tick = (smp_end && cpha1) ? 5'(ticks_mid + 5'h01) :
      ticks_mid;
   wire tick_now = state_reg == ST_MASTER && tick_reg < last_tick &&
      div_reg == half_count - 6'h01;
   wire [4:0] tick_num = 5'(tick_reg + 5'h01);
   wire odd = tick_num[0];
   wire sample_sel = smp_end ? (cpha1 ? (odd && tick_num > 5'h01) : !odd) :
      (cpha1 ? !odd : odd);
   wire sample_tick = tick_now && sample_sel;
   wire out_tick = tick_now && (cpha1 == odd) && tick_num < ticks_mid;
   wire clk_tick = tick_now && tick_num <= ticks_mid;
   wire master_end = tick_now && tick_num == last_tick;
   // the input synchroniser lags the pin by two clocks, so each sampled
   // bit is shifted in two clocks late and the frame closes two late
   wire master_done = state_reg == ST_MASTER && end_pipe_reg[1];

   // serial input with direction override
   wire sdi_bit = sdi_sync_reg & pin_direction_bit.in_dir;
   wire [7:0] rx_shift_next = {rx_sh_reg[6:0], sdi_bit};
   wire shift_in = sample_pipe_reg[1];
   wire [7:0] master_byte = shift_in ? rx_shift_next : rx_sh_reg;

   // slave completion arrives as a toggle from the link domain
   wire slave_done = is_slave && done_sync_reg != done_seen_reg;
   wire rx_done = master_done || slave_done;
   wire [7:0] rx_byte = master_done ? master_byte : link_word_reg;

   // buffer write acceptance
   wire collision = buf_write &&
      (state_reg != ST_IDLE || write_collision_flag_reg);
   wire write_ok = buf_write && !collision;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (write_ok && is_master) begin
               state_next = ST_MASTER;
            end else if (write_ok && is_slave) begin
               state_next = ST_SLAVE;
            end
         end
         ST_MASTER: begin
            if (master_done) begin
               state_next = ST_IDLE;
            end
         end
         ST_SLAVE: begin
            if (slave_done) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (!en) begin
         state_next = ST_IDLE;
      end
   end

   // received byte overwrites the buffer even if still unread
   assign buffer_next = rx_done ? rx_byte :
      write_ok ? buf_wdata : buffer_reg;

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         buffer_reg <= BUFFER_RESET;
         tx_hold_reg <= BUFFER_RESET;
         bf_reg <= 1'b0;
         irq_reg <= 1'b0;
         write_collision_flag_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         buffer_reg <= buffer_next;
         if (write_ok) begin
            tx_hold_reg <= buf_wdata;
         end
         bf_reg <= rx_done || (bf_reg && !buf_read);
         irq_reg <= rx_done || (irq_reg && !irq_clear);
         write_collision_flag_reg <= collision || (write_collision_flag_reg && !write_collision_flag_clear);
      end
   end

   // synchronisers into the system domain
   always_ff @(posedge clock) begin
      if (rst) begin
         sdi_meta_reg <= 1'b0;
         sdi_sync_reg <= 1'b0;
         done_meta_reg <= 1'b0;
         done_sync_reg <= 1'b0;
         done_seen_reg <= 1'b0;
      end else begin
         sdi_meta_reg <= serial_in_pin;
         sdi_sync_reg <= sdi_meta_reg;
         done_meta_reg <= link_tog_reg;
         done_sync_reg <= done_meta_reg;
         done_seen_reg <= done_sync_reg;
      end
   end

   // master shift engine
   always_ff @(posedge clock) begin
      if (rst) begin
         div_reg <= 6'h00;
         tick_reg <= 5'h00;
         sck_reg <= 1'b0;
         sdo_reg <= 1'b0;
         tx_sh_reg <= BUFFER_RESET;
         rx_sh_reg <= BUFFER_RESET;
         sample_pipe_reg <= 2'b00;
         end_pipe_reg <= 2'b00;
      end else if (state_reg != ST_MASTER) begin
         div_reg <= 6'h00;
         tick_reg <= 5'h00;
         sample_pipe_reg <= 2'b00;
         end_pipe_reg <= 2'b00;
         sck_reg <= control_one.idle_high;
         if (write_ok && is_master) begin
            tx_sh_reg <= cpha1 ? buf_wdata : {buf_wdata[6:0], 1'b0};
            if (!cpha1) begin
               sdo_reg <= buf_wdata[7];
            end
         end
      end else begin
         div_reg <= tick_now ? 6'h00 : 6'(div_reg + 6'h01);
         if (tick_now) begin
            tick_reg <= tick_num;
         end
         if (clk_tick) begin
            sck_reg <= !sck_reg;
         end
         if (out_tick) begin
            sdo_reg <= tx_sh_reg[7];
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
         end
         sample_pipe_reg <= {sample_pipe_reg[0], sample_tick};
         end_pipe_reg <= {end_pipe_reg[0], master_end};
         if (shift_in) begin
            rx_sh_reg <= rx_shift_next;
         end
      end
   end

   // slave link domain, clocked by the incoming serial clock
   wire sample_clk = serial_clock_in ^ control_one.idle_high ^ cpha1;
   wire select_on = !pin_direction_bit.select_dir || !select_pin_n;
   wire link_off = !is_slave;
   wire link_rst = link_off || (ss_used && !select_on);
   wire link_in = serial_in_pin & pin_direction_bit.in_dir;
   wire [2:0] out_idx = 3'(link_out_reg - {2'b00, cpha1});
   wire slave_sdo = tx_hold_reg[~out_idx];

   always_ff @(posedge sample_clk or posedge link_rst) begin
      if (link_rst) begin
         link_rx_reg <= BUFFER_RESET;
         link_bit_reg <= 3'h0;
      end else begin
         link_rx_reg <= {link_rx_reg[6:0], link_in};
         link_bit_reg <= 3'(link_bit_reg + 3'h1);
      end
   end

   // word and toggle survive select release so the handshake stays sound
   always_ff @(posedge sample_clk or posedge link_off) begin
      if (link_off) begin
         link_word_reg <= BUFFER_RESET;
         link_tog_reg <= 1'b0;
      end else if (link_bit_reg == 3'h7) begin
         link_word_reg <= {link_rx_reg[6:0], link_in};
         link_tog_reg <= !link_tog_reg;
      end
   end

   always_ff @(negedge sample_clk or posedge link_rst) begin
      if (link_rst) begin
         link_out_reg <= 3'h0;
      end else begin
         link_out_reg <= 3'(link_out_reg + 3'h1);
      end
   end

   // pins and status
   assign serial_clock_out = sck_reg;
   assign serial_clock_oe_n =
      !(is_master && !pin_direction_bit.clock_dir);
   assign serial_out_pin = is_master ? sdo_reg : slave_sdo;
   assign serial_out_oe_n = !((is_master || is_slave) &&
      !pin_direction_bit.out_dir);
   assign buf_rdata = buffer_reg;
   assign buffer_full_flag = bf_reg;
   assign serial_irq_flag = irq_reg;
   assign write_collision_flag = write_collision_flag_reg;
   assign busy = state_reg != ST_IDLE;

   // checks in the system domain
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   write_collision_flag_on_write_a: assert property (busy && buf_write |=> write_collision_flag_reg)
      else $error("busy write did not set collision flag");
   collision_drop_a: assert property (collision && !rx_done |=>
      $stable(buffer_reg))
      else $error("colliding write changed the buffer");
   write_collision_flag_hold_a: assert property (write_collision_flag_reg && !write_collision_flag_clear |=> write_collision_flag_reg
      && ($past(buf_write && !busy) -> !busy))
      else $error("collision flag lost or write let through");
   done_flags_a: assert property (rx_done |=> bf_reg && irq_reg
      && buffer_reg == $past(rx_byte))
      else $error("completed byte not posted");
   bf_read_clear_a: assert property (buf_read && !rx_done |=> !bf_reg)
      else $error("read did not clear buffer full");
   master_clock_drive_a: assert property (is_master
      && !pin_direction_bit.clock_dir |-> !serial_clock_oe_n)
      else $error("master did not drive serial clock");
   slave_clock_input_a: assert property (!is_master |->
      serial_clock_oe_n)
      else $error("serial clock driven outside master role");
   disabled_idle_a: assert property (!en |-> (serial_out_oe_n
      && serial_clock_oe_n) ##1 !busy)
      else $error("disabled port still active");
   frame_bound_a: assert property (state_reg == ST_IDLE && state_next ==
      ST_MASTER |=> busy [*3] ##[1:600] !busy)
      else $error("master frame did not finish in time");
   back_to_idle_a: assert property (rx_done && bf_reg |=>
      state_reg == ST_IDLE)
      else $error("unread byte blocked the next reception");
   frame_tail_a: assert property (master_end |-> ##2 (master_done
      && serial_clock_out == control_one.idle_high))
      else $error("master frame did not close with the clock idle");

   master_frame_c: cover property (busy ##[1:600] master_done);
   slave_frame_c: cover property (slave_done && !busy);
   collision_c: cover property (collision);
   overrun_c: cover property (rx_done && bf_reg);
   fast_frame_c: cover property (master_done && half_count == 6'h02);

endmodule : spi_serial_port
`default_nettype wire

// >>> common/spi_port_pkg.sv
// constants and carrier types of the serial peripheral port
package spi_port_pkg;

   // control_one bits 5:0
   typedef struct packed {
      logic enable;
      logic idle_high;
      logic [3:0] mode;
   } control_type;

   // serial_status_reg bits 7:6
   typedef struct packed {
      logic sample_at_end;
      logic edge_active_to_idle;
   } status_cfg_type;

   // pin_direction_bit per pin, 1 means input
   typedef struct packed {
      logic clock_dir;
      logic out_dir;
      logic in_dir;
      logic select_dir;
   } pin_dir_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MASTER = 2'b01,
      ST_SLAVE = 2'b10
   } state_type;

   localparam logic [3:0] MODE_MASTER_FAST = 4'h0;
   localparam logic [3:0] MODE_MASTER_MID = 4'h1;
   localparam logic [3:0] MODE_MASTER_SLOW = 4'h2;
   localparam logic [3:0] MODE_SLAVE_SELECT = 4'h4;
   localparam logic [3:0] MODE_SLAVE_FREE = 4'h5;

   // system clocks per serial clock period in master role
   localparam logic [6:0] RATE_FAST_DIV = 7'h04;
   localparam logic [6:0] RATE_MID_DIV = 7'h10;
   localparam logic [6:0] RATE_SLOW_DIV = 7'h40;

   localparam logic [4:0] BYTE_BITS = 5'h08;
   localparam logic [7:0] BUFFER_RESET = 8'h00;

endpackage : spi_port_pkg

// >>> test/spi_link_partner.sv
// far-side model: spi slave in master role, spi master in slave role
`timescale 1ns/1ps
`default_nettype none
module spi_link_partner (
   // 1 when this model sources the link clock
   input wire logic master_role,
   // link lines
   input wire logic sck_from_dut,
   input wire logic mosi,
   output logic sck_to_dut,
   output logic miso,
   output logic select_n
);
   logic [7:0] tx_reg = 8'h00;
   logic [7:0] rx_reg = 8'h00;
   logic drv = 1'b0;
   initial begin
      sck_to_dut = 1'b0;
      select_n = 1'b1;
   end
   assign miso = master_role ? drv : tx_reg[7];
   // sample on the leading edge, change on the trailing one
   always @(posedge sck_from_dut) begin
      if (!master_role) begin
         rx_reg <= {rx_reg[6:0], mosi};
      end
   end
   // spent bits are replaced by a changing pattern
   always @(negedge sck_from_dut) begin
      if (!master_role) begin
         tx_reg <= {tx_reg[6:0], ~tx_reg[0]};
      end
   end
   task automatic load(input logic [7:0] b);
      tx_reg = b;
   endtask : load
   // one byte at a 64 ns link period, clock still outside the frame
   task automatic send(input logic [7:0] b);
      select_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         drv = b[i];
         #16 sck_to_dut = 1'b1;
         rx_reg = {rx_reg[6:0], mosi};
         #32 sck_to_dut = 1'b0;
         #16;
      end
      select_n = 1'b1;
      drv = ~b[0];
   endtask : send
endmodule : spi_link_partner
`default_nettype wire

// >>> test/spi_serial_port_bench.sv
// self-checking bench of the serial peripheral port
`timescale 1ns/1ps
`default_nettype none
module spi_serial_port_bench
   import spi_port_pkg::*;
;
   logic clock, rst, buf_write, buf_read, write_collision_flag_clear, irq_clear;
   logic [7:0] buf_wdata, buf_rdata, tx, rx;
   control_type control_one;
   status_cfg_type status_cfg;
   pin_dir_type pin_direction_bit;
   logic buffer_full_flag, serial_irq_flag, write_collision_flag, busy;
   logic sck_out, sck_oe_n, sdo, sdo_oe_n, sck_in, sdi, sel_n, master_role;
   logic [31:0] seed = 32'h000126b9;
   int bad_count = 0;
   int total_checks = 0;
   int n;
   logic [3:0] modes [3] =
      '{MODE_MASTER_FAST, MODE_MASTER_MID, MODE_MASTER_SLOW};
   logic [6:0] divs [3] = '{RATE_FAST_DIV, RATE_MID_DIV, RATE_SLOW_DIV};
   spi_serial_port uut (.clock(clock), .rst(rst), .control_one(control_one),
      .status_cfg(status_cfg), .pin_direction_bit(pin_direction_bit),
      .buf_write(buf_write), .buf_wdata(buf_wdata), .buf_read(buf_read),
      .buf_rdata(buf_rdata), .write_collision_flag_clear(write_collision_flag_clear), .irq_clear(irq_clear),
      .buffer_full_flag(buffer_full_flag), .serial_irq_flag(serial_irq_flag),
      .write_collision_flag(write_collision_flag), .busy(busy),
      .serial_clock_in(sck_in), .serial_clock_out(sck_out),
      .serial_clock_oe_n(sck_oe_n), .serial_in_pin(sdi),
      .serial_out_pin(sdo), .serial_out_oe_n(sdo_oe_n), .select_pin_n(sel_n));
   // released lines fall to a pulled-down level
   spi_link_partner partner (.master_role(master_role),
      .sck_from_dut(!sck_oe_n && sck_out), .mosi(!sdo_oe_n && sdo),
      .sck_to_dut(sck_in), .miso(sdi), .select_n(sel_n));
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd
   // a master frame lasts eight serial clock periods
   function automatic logic [7:0] in_frame(input int cnt,
      input logic [6:0] div);
      return {7'h00, (cnt >= 8 * div - 4) && (cnt <= 8 * div + 2)};
   endfunction : in_frame
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic flag(input logic f, input logic e);
      check({7'h00, f}, {7'h00, e});
   endtask : flag
   task automatic step();
      @(posedge clock);
      #1;
   endtask : step
   task automatic write_byte(input logic [7:0] d);
      buf_wdata = d;
      buf_write = 1'b1;
      step();
      buf_write = 1'b0;
   endtask : write_byte
   task automatic strobes(input logic [2:0] s);
      {buf_read, write_collision_flag_clear, irq_clear} = s;
      step();
      {buf_read, write_collision_flag_clear, irq_clear} = 3'b000;
   endtask : strobes
   task automatic wait_full(output int cnt);
      cnt = 0;
      while (buffer_full_flag !== 1'b1 && cnt < 5000) begin
         step();
         cnt++;
      end
      if (cnt == 5000) begin
         bad_count++;
         wrap_up();
      end
   endtask : wait_full
   task automatic set_cfg(input control_type c, input pin_dir_type d);
      control_one.enable = 1'b0;
      step();
      pin_direction_bit = d;
      control_one = {1'b0, c[4:0]};
      step();
      control_one.enable = c.enable;
      step();
   endtask : set_cfg
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      rst = 1'b1;
      {buf_write, buf_read, write_collision_flag_clear, irq_clear, master_role} = 5'h00;
      buf_wdata = 8'h00;
      control_one = '0;
      status_cfg = 2'b01;
      pin_direction_bit = 4'hf;
      repeat (4) @(posedge clock);
      #1 rst = 1'b0;
      check(buf_rdata, BUFFER_RESET);
      flag(buffer_full_flag | serial_irq_flag | write_collision_flag |
         busy, 0);
      $display("reset test done");
      for (int m = 0; m < 3; m++) begin
         set_cfg({1'b1, 1'b0, modes[m]}, 4'b0011);
         tx = rnd();
         rx = rnd();
         partner.load(rx);
         write_byte(tx);
         step();
         flag(busy, 1);
         flag(sck_oe_n, 0);
         if (m == 0) begin
            write_byte(~tx);
            step();
            flag(write_collision_flag, 1);
         end
         wait_full(n);
         check(in_frame(n, divs[m]), 8'h01);
         check(buf_rdata, rx);
         check(partner.rx_reg, tx);
         flag(serial_irq_flag, 1);
         flag(sck_out, 1'b0);
         flag(busy, 0);
         if (m == 0) begin
            write_byte(8'h5a);
            step();
            flag(busy, 0);
            strobes(3'b010);
            flag(write_collision_flag, 0);
         end
         strobes(3'b100);
         flag(buffer_full_flag, 0);
         flag(serial_irq_flag, 1);
         strobes(3'b001);
         flag(serial_irq_flag, 0);
         $display("master test %0d done", m);
      end
      pin_direction_bit.clock_dir = 1'b1;
      step();
      flag(sck_oe_n, 1);
      master_role = 1'b1;
      set_cfg({1'b1, 1'b0, MODE_SLAVE_FREE}, 4'b1011);
      flag(sck_oe_n, 1);
      tx = rnd();
      rx = rnd();
      write_byte(tx);
      partner.send(rx);
      wait_full(n);
      check(buf_rdata, rx);
      check(partner.rx_reg, tx);
      flag(busy, 0);
      strobes(3'b101);
      tx = rnd();
      partner.send(rnd());
      partner.send(tx);
      repeat (6) step();
      check(buf_rdata, tx);
      flag(buffer_full_flag, 1);
      $display("slave test done");
      strobes(3'b101);
      control_one.enable = 1'b0;
      partner.send(rnd());
      repeat (6) step();
      flag(buffer_full_flag, 0);
      $display("disabled test done");
      wrap_up();
   end
endmodule : spi_serial_port_bench
`default_nettype wire
